// File: verilog/strap_led_pkg.sv
// Package for the mode strap and status indicator block.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
`default_nettype none

package strap_led_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int DEBOUNCE_TIME_US   = 10;
  localparam int DEBOUNCE_CYCLES    = (DEBOUNCE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int BLINK_DIVIDE       = 3;
  localparam int SIZE_STABLE_FRAMES = 2;

  // ---------------------------------------------------------------------------
  // Switch positions (bit index = position - 1)
  // ---------------------------------------------------------------------------
  localparam int SW_RESERVED_POS  = 0;
  localparam int SW_PATTERN_POS   = 1;
  localparam int SW_LANE_LO_POS   = 2;
  localparam int SW_LANE_HI_POS   = 3;
  localparam int SW_MON_FMT_POS   = 4;
  localparam int SW_MON_RES_POS   = 5;
  localparam int SW_MON_RATE_POS  = 6;
  localparam int SW_WORK_MODE_POS = 7;
  localparam int SWITCH_COUNT     = 8;

  // ---------------------------------------------------------------------------
  // Lane counts and reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] LANES_OFF_OFF = 3'h4;
  localparam logic [2:0] LANES_OFF_ON  = 3'h1;
  localparam logic [2:0] LANES_ON_OFF  = 3'h2;
  localparam logic [2:0] LANES_ON_ON   = 3'h3;
  localparam logic       TARGET_RESET_IDLE = 1'h1;

  typedef enum {MODE_DISPLAY, MODE_USB} work_mode_t;

  // Decoded configuration handed to the datapaths.
  typedef struct packed {
    logic [2:0] laneCount;
    logic       testPattern;
    logic       dviFormat;
    logic       res720;
    logic       rate30;
    logic       usbMode;
  } config_t;

  // Indicator set.
  typedef struct packed {
    logic inputSync;
    logic sizeLock;
    logic overflow;
    logic alignError;
    logic writerIdle;
    logic writeBlocked;
    logic readBlocked;
    logic outputSync;
  } leds_t;

endpackage : strap_led_pkg

`default_nettype wire

// File: verilog/input_debounce.sv
// Synchroniser and debouncer for one slow pin.
// Assumes the pin is asynchronous to clk_sys; output changes after a steady level.
`default_nettype none

module input_debounce #(
  parameter int   HOLD_CYCLES = strap_led_pkg::DEBOUNCE_CYCLES,
  parameter logic RESET_LEVEL = 1'h0
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic pinRaw,
  output var  logic level
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic          syncA_ff;
  logic          syncB_ff;
  logic [CW-1:0] count_ff;
  logic          level_ff;
  wire  logic    differs = syncB_ff != level_ff;
  wire  logic    settled = count_ff == CW'(HOLD_CYCLES - 1);

  // ---------------------------------------------------------------------------
  // Two-stage synchroniser.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncA_ff <= RESET_LEVEL;
      syncB_ff <= RESET_LEVEL;
    end else if (clkEn) begin
      syncA_ff <= pinRaw;
      syncB_ff <= syncA_ff;
    end
  end

  // Accept a new level only after it held for the full window.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_ff <= '0;
      level_ff <= RESET_LEVEL;
    end else if (clkEn) begin
      count_ff <= (differs && !settled) ? count_ff + CW'(1) : '0;
      if (differs && settled) begin
        level_ff <= syncB_ff;
      end
    end
  end

  assign level = level_ff;

endmodule : input_debounce

`default_nettype wire

// File: verilog/sync_blinker.sv
// Toggles a lamp once every DIVIDE frame-sync pulses.
// Assumes syncPulse is a same-clock one-cycle pulse.
`default_nettype none

module sync_blinker #(
  parameter int DIVIDE = strap_led_pkg::BLINK_DIVIDE
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic enable,
  input  wire logic syncPulse,
  output var  logic lamp
);

  // Counter width follows the divide ratio so other ratios still fit.
  localparam int CW = $clog2(DIVIDE + 1);

  logic [CW-1:0] count_ff;
  logic          lamp_ff;
  wire  logic    wrap = count_ff == CW'(DIVIDE - 1);

  // ---------------------------------------------------------------------------
  // Pulse counter with lamp toggle on wrap.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || (clkEn && !enable)) begin
      count_ff <= '0;
      lamp_ff  <= 1'h0;
    end else if (clkEn && syncPulse) begin
      count_ff <= wrap ? CW'(0) : count_ff + CW'(1);
      lamp_ff  <= wrap ? !lamp_ff : lamp_ff;
    end
  end

  assign lamp = lamp_ff;

endmodule : sync_blinker

`default_nettype wire

// File: verilog/mode_strap_and_status_leds.sv
// Mode strap decoder, target reset control and status lamp driver.
// Assumes status pulses come from logic on clk_sys; switches and button are raw pins.
`default_nettype none

module mode_strap_and_status_leds #(
  parameter int DEBOUNCE_CYCLES = strap_led_pkg::DEBOUNCE_CYCLES,
  parameter int DIM_WIDTH       = 12
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  input  wire logic                 resetButtonRaw,
  input  wire logic [7:0]           modeStrapSwitchRaw,
  input  wire logic                 buttonDisable,
  input  wire logic                 targetFrameSync,
  input  wire logic                 sizeMeasured,
  input  wire logic [DIM_WIDTH-1:0] measuredWidth,
  input  wire logic [DIM_WIDTH-1:0] measuredHeight,
  input  wire logic                 writeOverflow,
  input  wire logic                 frameSyncActive,
  input  wire logic                 alignFail,
  input  wire logic                 writerIdle,
  input  wire logic                 tableFull,
  input  wire logic                 noNewFrame,
  input  wire logic                 hostCapturing,
  input  wire logic                 usbFrameSync,
  input  wire logic                 monitorFrameSync,
  output var  logic                 targetReset_n,
  output var  logic                 videoHold,
  output var  logic                 dropInputFrame,
  output var  logic                 repeatLastFrame,
  output var  strap_led_pkg::config_t cfg,
  output var  logic                 inputSyncIndicator,
  output var  logic                 size_lock_indicator,
  output var  logic                 overflow_indicator,
  output var  logic                 align_error_indicator,
  output var  logic                 writer_idle_indicator,
  output var  logic                 write_blocked_indicator,
  output var  logic                 read_blocked_indicator,
  output var  logic                 output_sync_indicator
);

  // ---------------------------------------------------------------------------
  // Lane decode function
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] laneDecode(input logic hi, input logic lo);
    logic [2:0] n;
    case ({hi, lo})
      2'b00:   n = strap_led_pkg::LANES_OFF_OFF;
      2'b01:   n = strap_led_pkg::LANES_OFF_ON;
      2'b10:   n = strap_led_pkg::LANES_ON_OFF;
      default: n = strap_led_pkg::LANES_ON_ON;
    endcase
    return n;
  endfunction : laneDecode

  // ---------------------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------------------
  logic       buttonHeld;
  logic [7:0] sw;

  // Button and each switch go through their own synchroniser and debouncer.
  input_debounce #(.HOLD_CYCLES(DEBOUNCE_CYCLES), .RESET_LEVEL(1'h0)) u_btn (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clkEn   (clkEn),
    .pinRaw  (resetButtonRaw),
    .level   (buttonHeld)
  );

  for (genvar i = 0; i < strap_led_pkg::SWITCH_COUNT; i++) begin : g_sw
    input_debounce #(.HOLD_CYCLES(DEBOUNCE_CYCLES), .RESET_LEVEL(1'h0)) u_sw (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clkEn   (clkEn),
      .pinRaw  (modeStrapSwitchRaw[i]),
      .level   (sw[i])
    );
  end

  // ---------------------------------------------------------------------------
  // Working mode latch
  // ---------------------------------------------------------------------------
  // The mode is taken once, after the debouncer has had time to settle.
  localparam int SCW = $clog2(DEBOUNCE_CYCLES + 4);
  logic [SCW-1:0]                 settle_ff;
  logic                           modeLatched_ff;
  strap_led_pkg::work_mode_t      mode_ff;
  wire  logic settleDone = settle_ff == SCW'(DEBOUNCE_CYCLES + 3);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settle_ff      <= '0;
      modeLatched_ff <= 1'h0;
      mode_ff        <= strap_led_pkg::MODE_DISPLAY;
    end else if (clkEn && !modeLatched_ff) begin
      settle_ff <= settle_ff + SCW'(1);
      if (settleDone) begin
        modeLatched_ff <= 1'h1;
        mode_ff <= sw[strap_led_pkg::SW_WORK_MODE_POS] ? strap_led_pkg::MODE_USB
                                                       : strap_led_pkg::MODE_DISPLAY;
      end
    end
  end

  wire logic usbMode = mode_ff == strap_led_pkg::MODE_USB;

  // ---------------------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------------------
  wire logic [2:0] lanes = laneDecode(sw[strap_led_pkg::SW_LANE_HI_POS],
                                      sw[strap_led_pkg::SW_LANE_LO_POS]);
  wire logic dispSw = !usbMode;
  strap_led_pkg::config_t nxt_cfg;
  strap_led_pkg::config_t cfg_ff;

  // Display-only switches read as off in USB mode.
  always_comb begin
    nxt_cfg.laneCount   = lanes;
    nxt_cfg.testPattern = dispSw && sw[strap_led_pkg::SW_PATTERN_POS];
    nxt_cfg.dviFormat   = dispSw && sw[strap_led_pkg::SW_MON_FMT_POS];
    nxt_cfg.res720      = dispSw && sw[strap_led_pkg::SW_MON_RES_POS];
    nxt_cfg.rate30      = dispSw && sw[strap_led_pkg::SW_MON_RATE_POS];
    nxt_cfg.usbMode     = usbMode;
  end

  // ---------------------------------------------------------------------------
  // Target reset and transfer hold
  // ---------------------------------------------------------------------------
  wire logic pressed = buttonHeld && !buttonDisable;
  logic targetReset_n_ff;
  logic videoHold_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      targetReset_n_ff <= strap_led_pkg::TARGET_RESET_IDLE;
      videoHold_ff     <= 1'h0;
      cfg_ff           <= '0;
    end else if (clkEn) begin
      targetReset_n_ff <= !pressed;
      videoHold_ff     <= pressed;
      cfg_ff           <= nxt_cfg;
    end
  end

  // ---------------------------------------------------------------------------
  // Size stability tracking
  // ---------------------------------------------------------------------------
  logic [DIM_WIDTH-1:0] lastW_ff;
  logic [DIM_WIDTH-1:0] lastH_ff;
  logic [1:0]           same_ff;
  wire  logic sameSize = measuredWidth == lastW_ff && measuredHeight == lastH_ff;
  wire  logic sizeStable = same_ff >= 2'(strap_led_pkg::SIZE_STABLE_FRAMES);

  // Each new measurement matching the last one counts towards lock.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lastW_ff <= '0;
      lastH_ff <= '0;
      same_ff  <= '0;
    end else if (clkEn && sizeMeasured) begin
      lastW_ff <= measuredWidth;
      lastH_ff <= measuredHeight;
      if (!sameSize) begin
        same_ff <= '0;
      end else if (!sizeStable) begin
        same_ff <= same_ff + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Blink dividers
  // ---------------------------------------------------------------------------
  logic inBlink;
  logic usbBlink;
  logic monBlink;

  sync_blinker u_in (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clkEn     (clkEn),
    .enable    (1'h1),
    .syncPulse (targetFrameSync),
    .lamp      (inBlink)
  );

  sync_blinker u_usb (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clkEn     (clkEn),
    .enable    (usbMode),
    .syncPulse (usbFrameSync),
    .lamp      (usbBlink)
  );

  sync_blinker u_mon (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clkEn     (clkEn),
    .enable    (!usbMode),
    .syncPulse (monitorFrameSync),
    .lamp      (monBlink)
  );

  // ---------------------------------------------------------------------------
  // Indicator selection
  // ---------------------------------------------------------------------------
  strap_led_pkg::leds_t nxt_leds;
  strap_led_pkg::leds_t leds_ff;
  logic drop_ff;
  logic repeat_ff;

  always_comb begin
    nxt_leds.inputSync    = inBlink;
    nxt_leds.sizeLock     = sizeStable;
    nxt_leds.overflow     = usbMode ? frameSyncActive : writeOverflow;
    nxt_leds.alignError   = usbMode ? usbBlink : alignFail;
    nxt_leds.writerIdle   = !usbMode && writerIdle;
    nxt_leds.writeBlocked = !usbMode && tableFull;
    nxt_leds.readBlocked  = usbMode ? hostCapturing : noNewFrame;
    nxt_leds.outputSync   = usbMode ? usbBlink : monBlink;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      leds_ff   <= '0;
      drop_ff   <= 1'h0;
      repeat_ff <= 1'h0;
    end else if (clkEn) begin
      leds_ff   <= nxt_leds;
      drop_ff   <= !usbMode && tableFull;
      repeat_ff <= !usbMode && noNewFrame;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign targetReset_n           = targetReset_n_ff;
  assign videoHold               = videoHold_ff;
  assign dropInputFrame          = drop_ff;
  assign repeatLastFrame         = repeat_ff;
  assign cfg                     = cfg_ff;
  assign inputSyncIndicator      = leds_ff.inputSync;
  assign size_lock_indicator     = leds_ff.sizeLock;
  assign overflow_indicator      = leds_ff.overflow;
  assign align_error_indicator   = leds_ff.alignError;
  assign writer_idle_indicator   = leds_ff.writerIdle;
  assign write_blocked_indicator = leds_ff.writeBlocked;
  assign read_blocked_indicator  = leds_ff.readBlocked;
  assign output_sync_indicator   = leds_ff.outputSync;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_reset_follows;
    @(posedge clk_sys) disable iff (rst)
      clkEn ##0 pressed |=> !targetReset_n && videoHold;
  endproperty
  a_reset_follows: assert property (p_reset_follows) else $error("reset not driven");

  property p_disable;
    @(posedge clk_sys) disable iff (rst)
      clkEn ##0 buttonDisable |=> targetReset_n && !videoHold;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled button acted");

  property p_usb_quiet;
    @(posedge clk_sys) disable iff (rst)
      clkEn ##0 usbMode |=> !writer_idle_indicator && !write_blocked_indicator;
  endproperty
  a_usb_quiet: assert property (p_usb_quiet) else $error("usb lamps lit");

  property p_usb_pattern;
    @(posedge clk_sys) disable iff (rst)
      clkEn ##0 usbMode |=> !cfg.testPattern && !cfg.dviFormat && !cfg.res720 && !cfg.rate30;
  endproperty
  a_usb_pattern: assert property (p_usb_pattern) else $error("usb honoured pattern");

  property p_mode_fixed;
    @(posedge clk_sys) disable iff (rst)
      modeLatched_ff |=> $stable(mode_ff);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed");

  property p_overflow;
    @(posedge clk_sys) disable iff (rst)
      clkEn ##0 !usbMode |=> overflow_indicator == $past(writeOverflow);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow lamp wrong");

  property p_read_usb;
    @(posedge clk_sys) disable iff (rst)
      clkEn ##0 usbMode |=> read_blocked_indicator == $past(hostCapturing);
  endproperty
  a_read_usb: assert property (p_read_usb) else $error("read lamp wrong");

  property p_drop;
    @(posedge clk_sys) disable iff (rst)
      clkEn ##0 (!usbMode && tableFull) |=> dropInputFrame && write_blocked_indicator;
  endproperty
  a_drop: assert property (p_drop) else $error("frame not dropped");

endmodule : mode_strap_and_status_leds

`default_nettype wire

// File: tb/sensor_model.sv
// Behavioural stand-in for the target image sensor on the far side of the block.
// Assumes it shares clk_sys with the block and sees the block's target reset pin.
`default_nettype none

module sensor_model (
  input  wire logic clk_sys,
  input  wire logic targetReset_n,
  input  wire logic run,
  output var  logic frameSync
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Frame timing
  // ---------------------------------------------------------------------------
  logic [1:0] phase_ff = 2'h0;

  // The sync pulse lasts one cycle, once every fourth cycle.
  // A sensor held in reset sends no frames.
  initial frameSync = 1'h0;
  always @(posedge clk_sys) begin
    phase_ff  <= phase_ff + 2'h1;
    frameSync <= run && targetReset_n && (phase_ff == 2'h3);
  end

endmodule : sensor_model

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: one display-mode and one USB-mode copy of the block.
// Assumes the package, the design files and the sensor model are compiled first.
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------------
  typedef struct packed {logic [6:0] in; logic [6:0] expD; logic [3:0] expU;} row_t;
  logic                   clk_sys = 1'h0;
  logic                   rst     = 1'h1;
  logic                   clkEn   = 1'h1;
  logic                   btn     = 1'h0;
  logic                   btnOff  = 1'h0;
  logic                   run     = 1'h0;
  logic                   sizeM   = 1'h0;
  logic                   usbSync = 1'h0;
  logic                   monSync = 1'h0;
  logic [7:0]             sw      = 8'h00;
  logic [23:0]            dim     = 24'h000000;
  logic [6:0]             lvl     = 7'h00;
  logic                   fs;
  logic [7:0]             swInst [2];
  logic                   rstN   [2];
  logic                   hold   [2];
  logic                   drop   [2];
  logic                   rep    [2];
  strap_led_pkg::config_t cfg    [2];
  strap_led_pkg::leds_t   leds   [2];
  int                     failures = 0;
  int                     n_checks = 0;
  int                     fsCount  = 0;
  row_t rows [9] = '{'{7'h00, 7'h00, 4'h0}, '{7'h01, 7'h40, 4'h0}, '{7'h02, 7'h00, 4'h8},
                     '{7'h04, 7'h20, 4'h0}, '{7'h08, 7'h10, 4'h0}, '{7'h10, 7'h0a, 4'h0},
                     '{7'h20, 7'h05, 4'h0}, '{7'h40, 7'h00, 4'h1}, '{7'h7f, 7'h7f, 4'h9}};
  logic [7:0]  swRows [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'hf2, 8'h76};
  logic [23:0] dimRows [8] = '{24'h2801e0, 24'h2801e0, 24'h2801e0, 24'h1401e0, 24'h1401e0,
                              24'h140168, 24'h140168, 24'h140168};
  logic [7:0]  lockExp     = 8'h84;

  // ---------------------------------------------------------------------------
  // Devices
  // ---------------------------------------------------------------------------
  // Copy 0 starts in display mode, copy 1 has position 8 on at power-up.
  assign swInst[0] = sw;
  assign swInst[1] = sw | 8'h80;
  for (genvar m = 0; m < 2; m++) begin : g_dut
    mode_strap_and_status_leds #(.DEBOUNCE_CYCLES(4), .DIM_WIDTH(12))
      i_mode_strap_and_status_leds (
      .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .resetButtonRaw(btn),
      .modeStrapSwitchRaw(swInst[m]), .buttonDisable(btnOff), .targetFrameSync(fs),
      .sizeMeasured(sizeM), .measuredWidth(dim[23:12]), .measuredHeight(dim[11:0]),
      .writeOverflow(lvl[0]), .frameSyncActive(lvl[1]), .alignFail(lvl[2]),
      .writerIdle(lvl[3]), .tableFull(lvl[4]), .noNewFrame(lvl[5]),
      .hostCapturing(lvl[6]), .usbFrameSync(usbSync), .monitorFrameSync(monSync),
      .targetReset_n(rstN[m]), .videoHold(hold[m]), .dropInputFrame(drop[m]),
      .repeatLastFrame(rep[m]), .cfg(cfg[m]),
      .inputSyncIndicator(leds[m].inputSync), .size_lock_indicator(leds[m].sizeLock),
      .overflow_indicator(leds[m].overflow), .align_error_indicator(leds[m].alignError),
      .writer_idle_indicator(leds[m].writerIdle),
      .write_blocked_indicator(leds[m].writeBlocked),
      .read_blocked_indicator(leds[m].readBlocked),
      .output_sync_indicator(leds[m].outputSync));
  end
  sensor_model i_sensor_model (.clk_sys(clk_sys), .targetReset_n(rstN[0]), .run(run),
                               .frameSync(fs));

  // Grouped lamp views for the row and sync checks.
  wire logic [6:0] dispLv = {leds[0].overflow, leds[0].alignError, leds[0].writerIdle,
                             leds[0].writeBlocked, leds[0].readBlocked, drop[0], rep[0]};
  wire logic [3:0] usbLv  = {leds[1].overflow, leds[1].writerIdle, leds[1].writeBlocked,
                             leds[1].readBlocked};
  wire logic [2:0] outLv  = {leds[0].outputSync, leds[1].outputSync, leds[1].alignError};

  // Clock and a count of the sensor's frame syncs.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (fs) fsCount <= fsCount + 1;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic final_report();
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Waits a bounded time for the target reset pin to reach a level.
  task automatic wait_reset(input logic v);
    int k;
    for (k = 0; k < 30 && rstN[0] !== v; k++) tick(1);
    if (rstN[0] !== v) begin
      failures++;
      final_report();
    end
  endtask : wait_reset

  // Expected configuration worked out from the switch table.
  function automatic strap_led_pkg::config_t exp_cfg(input logic [7:0] s, input logic usb);
    strap_led_pkg::config_t c;
    c = '0;
    case (s[3:2])
      2'h0:    c.laneCount = 3'h4;
      2'h1:    c.laneCount = 3'h1;
      2'h2:    c.laneCount = 3'h2;
      default: c.laneCount = 3'h3;
    endcase
    c.usbMode = usb;
    if (!usb) begin
      c.testPattern = s[1];
      c.dviFormat   = s[4];
      c.res720      = s[5];
      c.rate30      = s[6];
    end
    return c;
  endfunction : exp_cfg

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    tick(8);
    `CHK({rstN[0], leds[0], leds[1]}, 17'h10000)
    rst = 1'h0;
    tick(20);
    // Level status rows.
    foreach (rows[i]) begin
      lvl = rows[i].in;
      tick(2);
      `CHK(dispLv, rows[i].expD)
      `CHK(usbLv, rows[i].expU)
    end
    lvl = 7'h00;
    // Switch rows; 8'hf2 also turns position 8 on long after power-up.
    foreach (swRows[i]) begin
      sw = swRows[i];
      tick(10);
      `CHK(cfg[0], exp_cfg(sw, 1'h0))
      `CHK(cfg[1], exp_cfg(sw, 1'h1))
    end
    // A short switch glitch and a short button press are ignored.
    sw = 8'h0c;
    btn = 1'h1;
    tick(2);
    sw = 8'h00;
    btn = 1'h0;
    tick(10);
    `CHK({cfg[0].laneCount, rstN[0]}, 4'h9)
    // A held button resets the target and holds video until release.
    btn = 1'h1;
    wait_reset(1'h0);
    `CHK({hold[0], rstN[1], hold[1]}, 3'h5)
    btn = 1'h0;
    wait_reset(1'h1);
    tick(1);
    `CHK({hold[0], hold[1]}, 2'h0)
    // With the host setting on, the button does nothing.
    btnOff = 1'h1;
    btn = 1'h1;
    repeat (15) begin
      tick(1);
      `CHK({rstN[0], hold[0]}, 2'h2)
    end
    btn = 1'h0;
    tick(10);
    btnOff = 1'h0;
    // Sensor frame syncs drive the input lamp in both modes.
    run = 1'h1;
    tick(43);
    run = 1'h0;
    tick(4);
    `CHK({leds[0].inputSync, leds[1].inputSync}, {2{(fsCount / 3) % 2 == 1}})
    // Output syncs; pulses 8 and 9 arrive back to back.
    for (int k = 1; k <= 9; k++) begin
      usbSync = 1'h1;
      monSync = 1'h1;
      tick(1);
      if (k != 8) begin
        usbSync = 1'h0;
        monSync = 1'h0;
        tick(3);
        `CHK(outLv, {3{(k / 3) % 2 == 1}})
      end
    end
    // With the clock enable low, pulses are not counted and the lamps hold.
    clkEn = 1'h0;
    usbSync = 1'h1;
    monSync = 1'h1;
    tick(3);
    usbSync = 1'h0;
    monSync = 1'h0;
    clkEn = 1'h1;
    tick(2);
    `CHK(outLv, 3'h7)
    // Size lock needs steady measurements and drops on a width or height change.
    foreach (dimRows[i]) begin
      dim = dimRows[i];
      sizeM = 1'h1;
      tick(1);
      sizeM = 1'h0;
      tick(3);
      `CHK(leds[0].sizeLock, lockExp[i])
    end
    final_report();
  end

endmodule : testbench

`default_nettype wire
